// [adc_result_compare_config_regs.sv]
// Overview of operation
// RULE_01 - 12-bit: top four bits in high low-nibble
// RULE_02 - 10-bit: top two bits in high bits 1:0
// RULE_03 - 10-bit: result bits 11:10 forced zero
// RULE_04 - 8-bit: result bits 11:8 zero, high empty
// RULE_05 - Load on completion unless compare fails
// RULE_06 - Compare event stores result minus compare value
// RULE_07 - High read blocks transfers until low read
// RULE_08 - Completions while blocked are discarded
// RULE_09 - 8-bit mode has no read interlock
// RULE_10 - Resolution change invalidates both result registers
// RULE_11 - Low holds eight low result bits
// RULE_12 - 12-bit: compare high four bits used
// RULE_13 - 10-bit: compare high bits 9:8 used
// RULE_14 - 8-bit: compare high register ignored
// RULE_15 - Compare low bits always matched against result
// RULE_16 - Config bit 7 selects low power
// RULE_17 - Config bits 6:5 divide by 1/2/4/8
// RULE_18 - Config bit 4 selects long sample
// RULE_19 - Config bits 3:2 select resolution
// RULE_20 - Config bits 1:0 select input clock
// RULE_21 - Pin register bit n governs channel n
// RULE_22 - Set bit removes digital port control
// RULE_23 - Done flag cleared by control write/low read
// RULE_24 - Disabled pin: no drive, reads zero, no pullup
`timescale 1ns/1ns
`default_nettype none

module adc_result_compare_config_regs #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conversion_done,
  input wire logic [11:0] raw_result,
  input wire logic alternate_clock,
  input wire logic internal_async_clock,
  input wire logic [CHANNELS-1:0] port_pin_in,
  output logic [CHANNELS-1:0] port_read_value,
  output logic [CHANNELS-1:0] pin_disable_ch,
  output logic converter_clock,
  output logic low_power_select,
  output logic long_sample_select,
  output logic [1:0] resolution,
  output logic [1:0] clock_divide_select,
  output logic [1:0] input_clock_select,
  output logic conversion_done_flag,
  output logic compare_enable
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [11:0] result;
  logic [7:0] compare_value_high;
  logic [7:0] compare_value_low;
  logic [7:0] converter_config;
  logic compare_greater;
  logic transfer_lock;
  logic half_phase;
  logic [adc_regs_pkg::DIV_WIDTH-1:0] divide_count;

  logic setup_phase;
  logic write_done;
  logic read_done;
  logic read_high;
  logic read_low;
  logic write_config;
  logic mode_change;
  logic [11:0] store_value;
  logic compare_true;
  logic transfer;
  logic done_set;
  logic done_clear;
  logic source_tick;
  logic [adc_regs_pkg::DIV_WIDTH-1:0] divide_last;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign setup_phase = psel && !penable;
  assign write_done = psel && penable && pready && pwrite;
  assign read_done = psel && penable && pready && !pwrite;
  assign read_high = read_done && (paddr == adc_regs_pkg::OFS_RESULT_HIGH);
  assign read_low = read_done && (paddr == adc_regs_pkg::OFS_RESULT_LOW);
  assign write_config = write_done && (paddr == adc_regs_pkg::OFS_CONVERTER_CONFIG);
  assign mode_change = write_config && (pwdata[adc_regs_pkg::CFG_RES_HI:adc_regs_pkg::CFG_RES_LO]
                       != resolution);

  // ************************************************************
  // Result path
  // ************************************************************
  result_former former (
    .resolution(resolution),
    .raw_result(raw_result),
    .compare_value_high(compare_value_high),
    .compare_value_low(compare_value_low),
    .compare_enable(compare_enable),
    .compare_greater(compare_greater),
    .store_value(store_value),
    .compare_true(compare_true)
  );

  // Failed compares and blocked completions leave the result registers alone
  assign done_set = conversion_done && (!compare_enable || compare_true); // [RULE_05]
  assign transfer = done_set && !transfer_lock; // [RULE_07] [RULE_08]

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result <= adc_regs_pkg::RESULT_RESET;
    end else if (ce) begin
      // Old data would be misaligned for the new width, so drop it
      if (mode_change) begin
        result <= adc_regs_pkg::RESULT_RESET; // [RULE_10]
      end else if (transfer) begin
        result <= store_value; // [RULE_05] [RULE_11]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      transfer_lock <= 1'b0;
    end else if (ce) begin
      if (mode_change || read_low) begin
        transfer_lock <= 1'b0; // [RULE_07]
      end else if (read_high && resolution != adc_regs_pkg::RES_8) begin
        transfer_lock <= 1'b1; // [RULE_07] [RULE_09]
      end
    end
  end

  // Set beats a clear landing in the same cycle
  assign done_clear = read_low ||
                      (write_done && paddr == adc_regs_pkg::OFS_STATUS_CONTROL_ONE);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conversion_done_flag <= 1'b0;
    end else if (ce) begin
      if (done_set) begin
        conversion_done_flag <= 1'b1;
      end else if (done_clear) begin
        conversion_done_flag <= 1'b0; // [RULE_23]
      end
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      compare_value_high <= adc_regs_pkg::REG_RESET;
      compare_value_low <= adc_regs_pkg::REG_RESET;
      converter_config <= adc_regs_pkg::REG_RESET;
      pin_disable_ch <= '0;
      compare_enable <= 1'b0;
      compare_greater <= 1'b0;
    end else if (ce && write_done) begin
      unique case (paddr)
        adc_regs_pkg::OFS_COMPARE_HIGH: compare_value_high <= pwdata[7:0];
        adc_regs_pkg::OFS_COMPARE_LOW: compare_value_low <= pwdata[7:0];
        adc_regs_pkg::OFS_CONVERTER_CONFIG: converter_config <= pwdata[7:0];
        adc_regs_pkg::OFS_PIN_DISABLE_LO: pin_disable_ch <= pwdata[CHANNELS-1:0]; // [RULE_21]
        adc_regs_pkg::OFS_STATUS_CONTROL_TWO: begin
          compare_enable <= pwdata[adc_regs_pkg::SC2_COMPARE_ENABLE];
          compare_greater <= pwdata[adc_regs_pkg::SC2_COMPARE_GREATER];
        end
        default: begin
        end
      endcase
    end
  end

  // Configuration fields straight out of the register
  assign low_power_select = converter_config[adc_regs_pkg::CFG_LOW_POWER]; // [RULE_16]
  assign clock_divide_select =
    converter_config[adc_regs_pkg::CFG_DIV_HI:adc_regs_pkg::CFG_DIV_LO]; // [RULE_17]
  assign long_sample_select = converter_config[adc_regs_pkg::CFG_LONG_SAMPLE]; // [RULE_18]
  assign resolution =
    converter_config[adc_regs_pkg::CFG_RES_HI:adc_regs_pkg::CFG_RES_LO]; // [RULE_19]
  assign input_clock_select =
    converter_config[adc_regs_pkg::CFG_CLK_HI:adc_regs_pkg::CFG_CLK_LO]; // [RULE_20]

  // ************************************************************
  // Converter clock enable
  // ************************************************************
  // Alternate and internal sources arrive as synchronous tick strobes
  always_comb begin
    unique case (input_clock_select)
      adc_regs_pkg::CLK_BUS: source_tick = 1'b1; // [RULE_20]
      adc_regs_pkg::CLK_BUS_HALF: source_tick = half_phase; // [RULE_20]
      adc_regs_pkg::CLK_ALT: source_tick = alternate_clock; // [RULE_20]
      adc_regs_pkg::CLK_ASYNC: source_tick = internal_async_clock; // [RULE_20]
    endcase
  end

  assign divide_last = adc_regs_pkg::DIV_WIDTH'((1 << clock_divide_select) - 1); // [RULE_17]

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      half_phase <= 1'b0;
    end else if (ce) begin
      half_phase <= !half_phase;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      divide_count <= '0;
      converter_clock <= 1'b0;
    end else if (ce) begin
      converter_clock <= source_tick && (divide_count >= divide_last); // [RULE_17]
      if (source_tick) begin
        divide_count <= (divide_count >= divide_last) ? '0
                        : divide_count + adc_regs_pkg::DIV_WIDTH'(1);
      end
    end
  end

  // ************************************************************
  // Pin gating
  // ************************************************************
  // Output drive and pullup gating live in the port; it reads pin_disable_ch
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : gate_pin
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          port_read_value[ch] <= 1'b0;
        end else if (ce) begin
          port_read_value[ch] <= port_pin_in[ch] && !pin_disable_ch[ch]; // [RULE_22] [RULE_24]
        end
      end
    end
  endgenerate

  // ************************************************************
  // Read mux and bus response
  // ************************************************************
  always_comb begin
    next_prdata = adc_regs_pkg::READ_ZERO;
    next_pslverr = 1'b0;
    unique case (paddr)
      adc_regs_pkg::OFS_RESULT_HIGH: next_prdata[3:0] = result[11:8]; // [RULE_01] [RULE_02]
      adc_regs_pkg::OFS_RESULT_LOW: next_prdata[7:0] = result[7:0]; // [RULE_11]
      adc_regs_pkg::OFS_COMPARE_HIGH: next_prdata[7:0] = compare_value_high;
      adc_regs_pkg::OFS_COMPARE_LOW: next_prdata[7:0] = compare_value_low;
      adc_regs_pkg::OFS_CONVERTER_CONFIG: next_prdata[7:0] = converter_config;
      adc_regs_pkg::OFS_PIN_DISABLE_LO: next_prdata[CHANNELS-1:0] = pin_disable_ch;
      adc_regs_pkg::OFS_STATUS_CONTROL_ONE:
        next_prdata[adc_regs_pkg::SC1_DONE] = conversion_done_flag;
      adc_regs_pkg::OFS_STATUS_CONTROL_TWO: begin
        next_prdata[adc_regs_pkg::SC2_COMPARE_ENABLE] = compare_enable;
        next_prdata[adc_regs_pkg::SC2_COMPARE_GREATER] = compare_greater;
      end
      default: next_pslverr = 1'b1;
    endcase
  end

  // One wait-free access phase: answer is prepared during setup
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= adc_regs_pkg::READ_ZERO;
    end else if (ce) begin
      pready <= setup_phase;
      pslverr <= setup_phase && next_pslverr;
      if (setup_phase) begin
        prdata <= pwrite ? adc_regs_pkg::READ_ZERO : next_prdata;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  compare_fail_hold_a: assert property (ce && conversion_done && compare_enable && !compare_true
    && !mode_change |=> $stable(result)) // [RULE_05]
    else $error("result changed after failed compare");

  compare_difference_a: assert property (ce && transfer && compare_enable && !mode_change
    |=> result == $past(store_value)) // [RULE_06]
    else $error("compare event did not store difference");

  high_read_lock_a: assert property (ce && read_high && !mode_change
    && resolution != adc_regs_pkg::RES_8 |=> transfer_lock) // [RULE_07]
    else $error("high read did not lock transfers");

  blocked_discard_a: assert property (ce && transfer_lock && !mode_change
    ##0 !read_low [*1] |=> $stable(result)) // [RULE_08]
    else $error("locked result changed");

  eight_bit_free_a: assert property (resolution == adc_regs_pkg::RES_8
    |-> !transfer_lock && result[11:8] == 4'h0) // [RULE_09] [RULE_04]
    else $error("8-bit mode locked or high bits set");

  ten_bit_mask_a: assert property (resolution == adc_regs_pkg::RES_10
    |-> result[11:10] == 2'h0) // [RULE_03]
    else $error("10-bit result has upper bits");

  mode_invalid_a: assert property (ce && mode_change
    |=> result == adc_regs_pkg::RESULT_RESET && !transfer_lock) // [RULE_10]
    else $error("resolution change kept old result");

  done_clear_a: assert property (ce && done_clear && !done_set
    |=> !conversion_done_flag) // [RULE_23]
    else $error("done flag not cleared");

  done_set_wins_a: assert property (ce && done_set |=> conversion_done_flag) // [RULE_23]
    else $error("done flag lost on completion");

  pin_read_zero_a: assert property (ce && pin_disable_ch[0]
    |=> port_read_value[0] == 1'b0) // [RULE_24]
    else $error("disabled pin read nonzero");

  // Difference rebuilt from the inputs, not taken from the former's output
  twelve_bit_difference_a: assert property (ce && transfer && compare_enable && !mode_change
    && resolution == adc_regs_pkg::RES_12
    |=> result == $past(raw_result) - {$past(compare_value_high[3:0]), $past(compare_value_low)})
    // [RULE_06] [RULE_12] [RULE_15]
    else $error("12-bit compare difference wrong");

  bus_clock_pulse_a: assert property (ce && input_clock_select == adc_regs_pkg::CLK_BUS
    && clock_divide_select == 2'h0 |=> converter_clock) // [RULE_17] [RULE_20]
    else $error("undivided bus clock missed a pulse");

endmodule : adc_result_compare_config_regs

`default_nettype wire

// [adc_regs_pkg.sv]
package adc_regs_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h00;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h04;
  localparam logic [7:0] OFS_COMPARE_HIGH = 8'h08;
  localparam logic [7:0] OFS_COMPARE_LOW = 8'h0c;
  localparam logic [7:0] OFS_CONVERTER_CONFIG = 8'h10;
  localparam logic [7:0] OFS_PIN_DISABLE_LO = 8'h14;
  localparam logic [7:0] OFS_STATUS_CONTROL_ONE = 8'h18;
  localparam logic [7:0] OFS_STATUS_CONTROL_TWO = 8'h1c;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_LOW_POWER = 7;
  localparam int CFG_DIV_HI = 6;
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_LONG_SAMPLE = 4;
  localparam int CFG_RES_HI = 3;
  localparam int CFG_RES_LO = 2;
  localparam int CFG_CLK_HI = 1;
  localparam int CFG_CLK_LO = 0;
  localparam int SC1_DONE = 7;
  localparam int SC2_COMPARE_ENABLE = 5;
  localparam int SC2_COMPARE_GREATER = 4;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [11:0] MASK_12 = 12'hfff;
  localparam logic [11:0] MASK_10 = 12'h3ff;
  localparam logic [11:0] MASK_8 = 12'h0ff;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam int DIV_WIDTH = 4;

endpackage : adc_regs_pkg

// [result_former.sv]
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Justify, compare and subtract one raw result
// ************************************************************
module result_former (
  input wire logic [1:0] resolution,
  input wire logic [11:0] raw_result,
  input wire logic [7:0] compare_value_high,
  input wire logic [7:0] compare_value_low,
  input wire logic compare_enable,
  input wire logic compare_greater,
  output logic [11:0] store_value,
  output logic compare_true
);

  logic [11:0] width_mask;
  logic [11:0] raw_masked;
  logic [11:0] compare_bits;
  logic [11:0] difference;

  always_comb begin
    unique case (resolution)
      adc_regs_pkg::RES_12: width_mask = adc_regs_pkg::MASK_12;
      adc_regs_pkg::RES_10: width_mask = adc_regs_pkg::MASK_10;
      // Reserved code behaves as 8-bit so stale upper bits never leak
      default: width_mask = adc_regs_pkg::MASK_8;
    endcase
  end

  // Upper result bits forced to zero by width
  assign raw_masked = raw_result & width_mask; // [RULE_03] [RULE_04]
  // High compare bits only count where the width has them
  assign compare_bits = {compare_value_high[3:0], compare_value_low} & width_mask; // [RULE_12] [RULE_13] [RULE_14] [RULE_15]
  assign compare_true = compare_greater ? (raw_masked >= compare_bits)
                                        : (raw_masked < compare_bits);
  // Result plus two's complement of compare value
  assign difference = (raw_masked + (~compare_bits + 12'h001)) & width_mask; // [RULE_06]
  assign store_value = compare_enable ? difference : raw_masked; // [RULE_06]

endmodule : result_former

`default_nettype wire

// [conv_core_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Converter core: one result after TICKS converter clocks
// ************************************************************
module conv_core_model #(
  parameter int TICKS = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic converter_clock,
  input wire logic start,
  input wire logic [11:0] sample,
  output logic conversion_done,
  output logic [11:0] raw_result
);
  logic busy;
  logic [11:0] held;
  int ticks;

  always_ff @(posedge ref_clk) begin
    conversion_done <= 1'b0;
    // Data only valid with the done pulse, so it churns otherwise
    raw_result <= ~raw_result;
    if (reset) begin
      busy <= 1'b0;
      ticks <= 0;
      raw_result <= 12'h000;
    end else if (start && !busy) begin
      busy <= 1'b1;
      held <= sample;
      ticks <= 0;
    end else if (busy && converter_clock) begin
      if (ticks == TICKS - 1) begin
        busy <= 1'b0;
        conversion_done <= 1'b1;
        raw_result <= held;
      end else begin
        ticks <= ticks + 1;
      end
    end
  end
endmodule : conv_core_model

`default_nettype wire

// [adc_result_compare_config_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module adc_result_compare_config_regs_tb;
  // ************************************************************
  // Signals
  // ************************************************************
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, last_err, conversion_done, start = 1'b0;
  logic [11:0] raw_result, sample = 12'h000;
  logic alternate_clock = 1'b0;
  logic internal_async_clock = 1'b0;
  logic [7:0] port_pin_in = 8'h00;
  logic ce = 1'b1;
  logic [7:0] port_read_value, pin_disable_ch, cfg, cyc = 8'h00;
  logic converter_clock, low_power_select, long_sample_select, conversion_done_flag;
  logic compare_enable;
  logic [1:0] resolution, clock_divide_select, input_clock_select, sel;
  logic [63:0] cases [6];
  int fail_count = 0;
  int tests_run = 0;
  int n;

  always #2 ref_clk = ~ref_clk;

  // Tick strobes of period 4 and 2 for the two outside sources
  always @(posedge ref_clk) begin
    cyc <= cyc + 8'h01;
    alternate_clock <= (cyc[1:0] == 2'h0);
    internal_async_clock <= cyc[0];
  end

  adc_result_compare_config_regs dut_u (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conversion_done(conversion_done),
    .raw_result(raw_result), .alternate_clock(alternate_clock),
    .internal_async_clock(internal_async_clock), .port_pin_in(port_pin_in),
    .port_read_value(port_read_value), .pin_disable_ch(pin_disable_ch),
    .converter_clock(converter_clock), .low_power_select(low_power_select),
    .long_sample_select(long_sample_select), .resolution(resolution),
    .clock_divide_select(clock_divide_select), .input_clock_select(input_clock_select),
    .conversion_done_flag(conversion_done_flag), .compare_enable(compare_enable));

  conv_core_model core_u (.ref_clk(ref_clk), .reset(reset), .converter_clock(converter_clock),
    .start(start), .sample(sample), .conversion_done(conversion_done),
    .raw_result(raw_result));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    last_err = pslverr;
    if (pready !== 1'b1) chk(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    // State written at the completing edge is only visible one edge later
    @(posedge ref_clk);
  endtask : xfer

  task automatic conv(input logic [11:0] v);
    int k;
    @(posedge ref_clk);
    start <= 1'b1;
    sample <= v;
    @(posedge ref_clk);
    start <= 1'b0;
    k = 0;
    while (conversion_done !== 1'b1 && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    if (conversion_done !== 1'b1) chk(32'h1, 32'h0);
    @(posedge ref_clk);
    #1;
  endtask : conv

  task automatic res(input logic [7:0] hi, input logic [7:0] lo);
    xfer(1'b0, adc_regs_pkg::OFS_RESULT_HIGH, 32'h0);
    chk(rdata, {24'h0, hi});
    xfer(1'b0, adc_regs_pkg::OFS_RESULT_LOW, 32'h0);
    chk(rdata, {24'h0, lo});
  endtask : res

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    // cfg, mode, cv high, cv low, {flag, raw}, high, low
    cases = '{64'h00_30_ff_40_1050_00_10, 64'h00_30_ff_40_0030_00_10,
      64'h04_30_02_00_01ff_00_00, 64'h04_30_02_00_1300_01_00,
      64'h04_20_02_00_1100_0f_00, 64'h08_30_05_00_1180_00_80};
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      xfer(1'b0, 8'(a * 4), 32'h0);
      chk(rdata, 32'h0);
    end
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    xfer(1'b1, adc_regs_pkg::OFS_RESULT_LOW, 32'hff);
    res(8'h00, 8'h00);
    for (int k = 0; k < 4; k++) begin
      sel = 2'(k);
      cfg = {sel[0], sel, sel[1], 2'h1, sel};
      xfer(1'b1, adc_regs_pkg::OFS_CONVERTER_CONFIG, {24'h0, cfg});
      chk({24'h0, low_power_select, clock_divide_select, long_sample_select, resolution,
        input_clock_select}, {24'h0, cfg});
      xfer(1'b0, adc_regs_pkg::OFS_CONVERTER_CONFIG, 32'h0);
      chk(rdata, {24'h0, cfg});
      // Let the divider settle on the new setting before counting
      repeat (20) @(posedge ref_clk);
      n = 0;
      repeat (64) begin
        @(posedge ref_clk);
        if (converter_clock === 1'b1) n++;
      end
      chk(32'(n), 32'(64 / ((k == 2 ? 4 : (k == 0 ? 1 : 2)) << k)));
    end
    xfer(1'b1, adc_regs_pkg::OFS_CONVERTER_CONFIG, 32'h04);
    conv(12'h9a5);
    chk({31'h0, conversion_done_flag}, 32'h1);
    res(8'h09, 8'ha5);
    chk({31'h0, conversion_done_flag}, 32'h0);
    conv(12'h123);
    xfer(1'b0, adc_regs_pkg::OFS_RESULT_HIGH, 32'h0);
    chk(rdata, 32'h01);
    conv(12'h456);
    xfer(1'b0, adc_regs_pkg::OFS_RESULT_LOW, 32'h0);
    chk(rdata, 32'h23);
    conv(12'h456);
    res(8'h04, 8'h56);
    conv(12'h7e1);
    xfer(1'b1, adc_regs_pkg::OFS_STATUS_CONTROL_ONE, 32'h0);
    chk({31'h0, conversion_done_flag}, 32'h0);
    xfer(1'b1, adc_regs_pkg::OFS_CONVERTER_CONFIG, 32'h08);
    res(8'h00, 8'h00);
    conv(12'hfff);
    res(8'h03, 8'hff);
    xfer(1'b1, adc_regs_pkg::OFS_CONVERTER_CONFIG, 32'h00);
    res(8'h00, 8'h00);
    conv(12'hf7c);
    res(8'h00, 8'h7c);
    xfer(1'b0, adc_regs_pkg::OFS_RESULT_HIGH, 32'h0);
    conv(12'h03e);
    xfer(1'b0, adc_regs_pkg::OFS_RESULT_LOW, 32'h0);
    chk(rdata, 32'h3e);
    foreach (cases[j]) begin
      xfer(1'b1, adc_regs_pkg::OFS_CONVERTER_CONFIG, {24'h0, cases[j][63:56]});
      xfer(1'b1, adc_regs_pkg::OFS_STATUS_CONTROL_TWO, {24'h0, cases[j][55:48]});
      chk({31'h0, compare_enable}, {31'h0, cases[j][53]});
      xfer(1'b1, adc_regs_pkg::OFS_COMPARE_HIGH, {24'h0, cases[j][47:40]});
      xfer(1'b1, adc_regs_pkg::OFS_COMPARE_LOW, {24'h0, cases[j][39:32]});
      conv(cases[j][27:16]);
      chk({31'h0, conversion_done_flag}, {31'h0, cases[j][28]});
      res(cases[j][15:8], cases[j][7:0]);
    end
    xfer(1'b1, adc_regs_pkg::OFS_STATUS_CONTROL_TWO, 32'h0);
    xfer(1'b1, adc_regs_pkg::OFS_PIN_DISABLE_LO, 32'ha5);
    xfer(1'b0, adc_regs_pkg::OFS_PIN_DISABLE_LO, 32'h0);
    chk(rdata, 32'ha5);
    chk({24'h0, pin_disable_ch}, 32'ha5);
    @(posedge ref_clk);
    port_pin_in <= 8'hff;
    repeat (3) @(posedge ref_clk);
    chk({24'h0, port_read_value}, 32'h5a);
    // Clock enable low must freeze the pin sampling
    ce <= 1'b0;
    port_pin_in <= 8'h00;
    repeat (3) @(posedge ref_clk);
    chk({24'h0, port_read_value}, 32'h5a);
    ce <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({24'h0, port_read_value}, 32'h00);
    finish_test();
  end
endmodule : adc_result_compare_config_regs_tb

`default_nettype wire
